// *** rtl/fsq_sequencer.sv ***
// Contract
// (R1) 40h then data starts program and verify
// (R2) Host repeats same address both program cycles
// (R3) One program command writes one byte
// (R4) Suspend off: ready low while programming
// (R5) Suspend on: program active while programming
// (R6) Program outcome in program error flag
// (R7) Host never reprograms a programmed address; the bench reprograms 05h once
// (R8) Block 0 refused unless enabled and unlocked
// (R9) Block 1 refused while its lock set
// (R10) Direct mode: never rewrite own control code
// (R11) Polling mode: program enters status mode
// (R12) 20h then D0h erases whole block
// (R13) Ready low throughout erase, then high
// (R14) Erase outcome in erase error flag
// (R15) Erase uses same block protection
// (R16) Host never erases during program suspend
// (R17) Polling mode: erase enters status mode
// (R18) Reads return status byte in status mode
// (R19) Status byte D4 prog, D5 erase, D7 ready
// (R20) 50h clears both error bits
// (R21) Errors set: program and erase refused
// (R22) FFh and reset give read array mode
// (R23) 70h enters status mode until FFh
// (R24) 50h is a single cycle command
// (R25) Bad erase confirm sets both errors
// (R26) Decode byte writes, hold first-cycle code
`timescale 1ns/100ps
module fsq_sequencer
    import fsq_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              bus_wr,
    input  wire logic              bus_rd,
    input  wire logic [ADDR_W-1:0] bus_addr,
    input  wire logic [DATA_W-1:0] bus_wdata,
    output logic      [DATA_W-1:0] bus_rdata,
    output logic                   bus_rvalid,
    input  wire logic              global_rewrite_enable,
    input  wire logic              block_zero_lock,
    input  wire logic              block_one_lock,
    input  wire logic              suspend_enable,
    input  wire logic              status_polling_rewrite_mode,
    output logic                   sequencer_ready_flag,
    output logic                   program_error_flag,
    output logic                   erase_error_flag,
    output logic                   program_active_flag,
    output logic                   read_status_flag
);
    fsq_regs_t         cur_ff;
    fsq_regs_t         nxt_regs;
    logic              mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [DATA_W-1:0] mem_wd;
    logic [ADDR_W-1:0] mem_ra;
    logic [DATA_W-1:0] mem_rdata;
    logic [DATA_W-1:0] status_byte;
    logic              prog_busy;
    logic              erase_busy;
    logic              refused;

    localparam logic [OFF_W-1:0] OFF_LAST = '1;

    function automatic logic fsq_refused(
        input logic [ADDR_W-1:0] addr,
        input logic              gre,
        input logic              lock0,
        input logic              lock1,
        input logic              any_err
    );
        logic blk;
        blk = addr[BLK_BIT];
        return any_err || (blk ? lock1 : (!gre || lock0));
    endfunction : fsq_refused

    fsq_byte_mem u_mem (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr_en   (mem_we),
        .wr_addr (mem_wa),
        .wr_data (mem_wd),
        .rd_addr (mem_ra),
        .rd_data (mem_rdata)
    );

    assign prog_busy  = cur_ff.state inside {FSQ_PROG_WAIT, FSQ_PROG_WRITE,
                                             FSQ_PROG_VERIFY, FSQ_PROG_CHECK};
    assign erase_busy = cur_ff.state inside {FSQ_ERASE_WRITE, FSQ_ERASE_VERIFY,
                                             FSQ_ERASE_CHECK};
    assign refused    = fsq_refused(bus_addr, global_rewrite_enable, block_zero_lock,
                                    block_one_lock, cur_ff.prog_err || cur_ff.erase_err); // [R8] [R9] [R15] [R21]

    always_comb begin
        status_byte                   = '0;
        status_byte[SR_PROG_ERR_BIT]  = cur_ff.prog_err;      // [R19]
        status_byte[SR_ERASE_ERR_BIT] = cur_ff.erase_err;     // [R19]
        status_byte[SR_READY_BIT]     = !(prog_busy || erase_busy); // [R11] [R17]
    end

    assign sequencer_ready_flag = !(erase_busy || (prog_busy && !suspend_enable)); // [R4] [R13]
    assign program_active_flag  = prog_busy && suspend_enable;                     // [R5]
    assign program_error_flag   = cur_ff.prog_err;
    assign erase_error_flag     = cur_ff.erase_err;
    assign read_status_flag     = cur_ff.status_mode;
    assign bus_rdata            = cur_ff.rdata;
    assign bus_rvalid           = cur_ff.rvalid;

    always_comb begin
        nxt_regs        = cur_ff;
        nxt_regs.rvalid = 1'b0;
        mem_we          = 1'b0;
        mem_wa          = cur_ff.tgt_addr;
        mem_wd          = ERASED_BYTE;
        mem_ra          = bus_addr;
        if (cur_ff.rd_pend) begin
            nxt_regs.rdata  = cur_ff.status_mode ? status_byte : mem_rdata; // [R18] [R23]
            nxt_regs.rvalid = 1'b1;
        end
        nxt_regs.rd_pend = bus_rd;
        case (cur_ff.state)
            FSQ_IDLE: begin
                if (bus_wr) begin
                    case (cur_ff.pend)
                        FSQ_PEND_PROG: begin
                            nxt_regs.pend = FSQ_PEND_NONE;
                            if (!refused) begin                     // [R1] [R2]
                                nxt_regs.state    = FSQ_PROG_WAIT;
                                nxt_regs.tgt_addr = bus_addr;
                                nxt_regs.wdata    = bus_wdata;     // [R3]
                                nxt_regs.cnt      = '0;
                                if (status_polling_rewrite_mode) begin
                                    nxt_regs.status_mode = 1'b1;   // [R11]
                                end
                            end
                        end
                        FSQ_PEND_ERASE: begin
                            nxt_regs.pend = FSQ_PEND_NONE;
                            if (bus_wdata == CMD_ERASE_GO) begin
                                if (!refused) begin                 // [R12]
                                    nxt_regs.state    = FSQ_ERASE_WRITE;
                                    nxt_regs.tgt_addr = {bus_addr[BLK_BIT], OFF_W'(0)};
                                    nxt_regs.cnt      = '0;
                                    if (status_polling_rewrite_mode) begin
                                        nxt_regs.status_mode = 1'b1; // [R17]
                                    end
                                end
                            end else if (bus_wdata == CMD_READ_ARRAY) begin
                                nxt_regs.status_mode = 1'b0;       // [R25]
                            end else begin
                                nxt_regs.prog_err  = 1'b1;         // [R25]
                                nxt_regs.erase_err = 1'b1;
                            end
                        end
                        default: begin                              // [R26]
                            case (bus_wdata)
                                CMD_READ_ARRAY:  nxt_regs.status_mode = 1'b0; // [R22]
                                CMD_READ_STATUS: nxt_regs.status_mode = 1'b1; // [R23]
                                CMD_CLEAR_STATUS: begin             // [R20] [R24]
                                    nxt_regs.prog_err  = ERR_RESET;
                                    nxt_regs.erase_err = ERR_RESET;
                                end
                                CMD_PROGRAM:     nxt_regs.pend = FSQ_PEND_PROG;
                                CMD_ERASE:       nxt_regs.pend = FSQ_PEND_ERASE;
                                default: begin
                                    nxt_regs.prog_err  = 1'b1;
                                    nxt_regs.erase_err = 1'b1;
                                end
                            endcase
                        end
                    endcase
                end
            end
            FSQ_PROG_WAIT: begin
                mem_ra       = cur_ff.tgt_addr;
                nxt_regs.cnt = cur_ff.cnt + CNT_W'(1);
                if (cur_ff.cnt == PROG_CYCLES - CNT_W'(1)) begin
                    nxt_regs.state = FSQ_PROG_WRITE;
                end
            end
            FSQ_PROG_WRITE: begin
                // Cells only clear bits, so an old value survives in the result
                mem_we         = 1'b1;
                mem_wd         = cur_ff.wdata & mem_rdata;
                mem_ra         = cur_ff.tgt_addr;
                nxt_regs.state = FSQ_PROG_VERIFY;
            end
            FSQ_PROG_VERIFY: begin
                mem_ra         = cur_ff.tgt_addr;
                nxt_regs.state = FSQ_PROG_CHECK;
            end
            FSQ_PROG_CHECK: begin
                if (mem_rdata != cur_ff.wdata) begin
                    nxt_regs.prog_err = 1'b1;                      // [R6]
                end
                nxt_regs.state = FSQ_IDLE;
            end
            FSQ_ERASE_WRITE: begin
                mem_we                        = 1'b1;
                nxt_regs.tgt_addr[OFF_W-1:0]  = cur_ff.tgt_addr[OFF_W-1:0] + OFF_W'(1);
                if (cur_ff.tgt_addr[OFF_W-1:0] == OFF_LAST) begin
                    nxt_regs.state = FSQ_ERASE_VERIFY;
                end
            end
            FSQ_ERASE_VERIFY: begin
                mem_ra                       = cur_ff.tgt_addr;
                nxt_regs.cnt                 = CNT_W'(1);
                nxt_regs.tgt_addr[OFF_W-1:0] = cur_ff.tgt_addr[OFF_W-1:0] + OFF_W'(1);
                if (cur_ff.cnt != '0 && mem_rdata != ERASED_BYTE) begin
                    nxt_regs.erase_err = 1'b1;                     // [R14]
                end
                if (cur_ff.tgt_addr[OFF_W-1:0] == OFF_LAST) begin
                    nxt_regs.state = FSQ_ERASE_CHECK;
                end
            end
            FSQ_ERASE_CHECK: begin
                if (mem_rdata != ERASED_BYTE) begin
                    nxt_regs.erase_err = 1'b1;                     // [R14]
                end
                nxt_regs.state = FSQ_IDLE;
            end
            default: nxt_regs.state = FSQ_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur_ff             <= '0;
            cur_ff.state       <= FSQ_IDLE;
            cur_ff.pend        <= FSQ_PEND_NONE;
            cur_ff.status_mode <= 1'b0;                            // [R22]
            cur_ff.prog_err    <= ERR_RESET;
            cur_ff.erase_err   <= ERR_RESET;
        end else begin
            cur_ff <= nxt_regs;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic cmd_first;
    assign cmd_first = cur_ff.state == FSQ_IDLE && bus_wr;

    a_prog_start: assert property ( // [R1]
        cmd_first && cur_ff.pend == FSQ_PEND_PROG && !refused
        |=> cur_ff.state == FSQ_PROG_WAIT && cur_ff.wdata == $past(bus_wdata))
        else $error("program did not start");
    a_ready_prog: assert property (prog_busy && !suspend_enable |-> !sequencer_ready_flag) // [R4]
        else $error("ready high during program");
    a_prog_active: assert property ( // [R5]
        $rose(prog_busy) && suspend_enable
        |-> program_active_flag && sequencer_ready_flag)
        else $error("program active flag wrong");
    a_prog_bound: assert property ($rose(prog_busy) |-> ##[1:30] !prog_busy) // [R6]
        else $error("program never ended");
    a_blk0_refuse: assert property ( // [R8]
        cmd_first && cur_ff.pend != FSQ_PEND_NONE
        && !bus_addr[BLK_BIT] && (!global_rewrite_enable || block_zero_lock)
        |=> cur_ff.state == FSQ_IDLE)
        else $error("block 0 rewrite not refused");
    a_blk1_refuse: assert property ( // [R9]
        cmd_first && cur_ff.pend != FSQ_PEND_NONE
        && bus_addr[BLK_BIT] && block_one_lock |=> cur_ff.state == FSQ_IDLE)
        else $error("block 1 rewrite not refused");
    a_err_refuse: assert property ( // [R21]
        cmd_first && (cur_ff.prog_err || cur_ff.erase_err)
        |=> !prog_busy && !erase_busy)
        else $error("command taken with error set");
    a_poll_status: assert property ( // [R11]
        (!prog_busy && !erase_busy) ##1
        (prog_busy || erase_busy) && $past(status_polling_rewrite_mode)
        |-> cur_ff.status_mode && !status_byte[SR_READY_BIT])
        else $error("polling mode missed status");
    a_erase_ready: assert property ( // [R13]
        $rose(erase_busy) |-> !sequencer_ready_flag
        ##1 !sequencer_ready_flag[*8])
        else $error("ready high during erase");
    a_clear_status: assert property ( // [R20]
        cmd_first && cur_ff.pend == FSQ_PEND_NONE
        && bus_wdata == CMD_CLEAR_STATUS |=> !program_error_flag && !erase_error_flag)
        else $error("clear status failed");
    a_seq_error: assert property ( // [R25]
        cmd_first && cur_ff.pend == FSQ_PEND_ERASE
        && bus_wdata != CMD_ERASE_GO && bus_wdata != CMD_READ_ARRAY
        |=> program_error_flag && erase_error_flag)
        else $error("bad erase confirm not flagged");
    a_status_read: assert property ( // [R18]
        bus_rd && cur_ff.status_mode ##1 cur_ff.status_mode
        |=> bus_rvalid && bus_rdata == $past(status_byte))
        else $error("status byte not returned");
    a_read_array: assert property ( // [R22]
        cmd_first && cur_ff.pend == FSQ_PEND_NONE
        && bus_wdata == CMD_READ_ARRAY |=> !read_status_flag)
        else $error("read array not entered");

    c_prog_done:  cover property ($fell(prog_busy) && !program_error_flag);
    c_prog_fail:  cover property ($fell(prog_busy) && program_error_flag);
    c_erase_done: cover property ($fell(erase_busy));
    c_stat_read:  cover property (bus_rvalid && read_status_flag);
endmodule : fsq_sequencer

// *** rtl/fsq_pkg.sv ***
package fsq_pkg;
    localparam int          ADDR_W           = 6;
    localparam int          DATA_W           = 8;
    localparam int          BLK_BIT          = 5;
    localparam int          OFF_W            = 5;
    localparam int          WORDS            = 64;
    localparam int          CNT_W            = 8;

    localparam logic [7:0]  CMD_READ_ARRAY   = 8'hff;
    localparam logic [7:0]  CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0]  CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0]  CMD_PROGRAM      = 8'h40;
    localparam logic [7:0]  CMD_ERASE        = 8'h20;
    localparam logic [7:0]  CMD_ERASE_GO     = 8'hd0;
    localparam logic [7:0]  ERASED_BYTE      = 8'hff;

    localparam int          SR_PROG_ERR_BIT  = 4;
    localparam int          SR_ERASE_ERR_BIT = 5;
    localparam int          SR_READY_BIT     = 7;
    localparam logic        ERR_RESET        = 1'b0;

    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          PROG_TIME_NS     = 200;
    localparam logic [CNT_W-1:0] PROG_CYCLES =
        CNT_W'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        FSQ_IDLE,
        FSQ_PROG_WAIT,
        FSQ_PROG_WRITE,
        FSQ_PROG_VERIFY,
        FSQ_PROG_CHECK,
        FSQ_ERASE_WRITE,
        FSQ_ERASE_VERIFY,
        FSQ_ERASE_CHECK
    } fsq_state_t;

    typedef enum logic [1:0] {
        FSQ_PEND_NONE,
        FSQ_PEND_PROG,
        FSQ_PEND_ERASE
    } fsq_pend_t;

    typedef struct packed {
        fsq_state_t          state;
        fsq_pend_t           pend;
        logic [ADDR_W-1:0]   tgt_addr;
        logic [DATA_W-1:0]   wdata;
        logic [CNT_W-1:0]    cnt;
        logic                status_mode;
        logic                prog_err;
        logic                erase_err;
        logic                rd_pend;
        logic [DATA_W-1:0]   rdata;
        logic                rvalid;
    } fsq_regs_t;
endpackage : fsq_pkg

// *** rtl/fsq_byte_mem.sv ***
`timescale 1ns/100ps
module fsq_byte_mem
    import fsq_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem_ff [WORDS];

    // Reset loads every word of the array with the erased byte
    for (genvar i = 0; i < WORDS; i++) begin : g_word
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                mem_ff[i] <= ERASED_BYTE;
            end else if (wr_en && wr_addr == ADDR_W'(i)) begin
                mem_ff[i] <= wr_data;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data <= ERASED_BYTE;
        end else begin
            rd_data <= mem_ff[rd_addr];
        end
    end
endmodule : fsq_byte_mem

// *** sim/fsq_host_model.sv ***
`timescale 1ns/100ps
module fsq_host_model
    import fsq_pkg::*;
(
    input  wire logic              sys_clk,
    output logic                   bus_wr,
    output logic                   bus_rd,
    output logic      [ADDR_W-1:0] bus_addr,
    output logic      [DATA_W-1:0] bus_wdata,
    input  wire logic [DATA_W-1:0] bus_rdata,
    input  wire logic              bus_rvalid
);
    initial begin
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        bus_addr  = 6'h15;
        bus_wdata = 8'ha5;
    end

    // Strobes drop low; address and data lines show the inverse of their last value
    task automatic release_bus();
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        bus_addr  = ~bus_addr;
        bus_wdata = ~bus_wdata;
    endtask : release_bus

    task automatic bus_write(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
        @(negedge sys_clk);
        bus_wr    = 1'b1;
        bus_addr  = addr;
        bus_wdata = data;
        @(negedge sys_clk);
        release_bus();
    endtask : bus_write

    // Callers keep away from any control code; the bench reprograms 05h once to fail verify
    task automatic program_byte(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
        bus_write(addr, CMD_PROGRAM);
        bus_write(addr, data);
    endtask : program_byte

    // This host never suspends, so erase never meets a suspended program
    task automatic erase_block(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] confirm);
        bus_write(addr, CMD_ERASE);
        bus_write(addr, confirm);
    endtask : erase_block

    task automatic bus_read(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data,
                            output logic timed_out);
        int n;
        @(negedge sys_clk);
        bus_rd    = 1'b1;
        bus_addr  = addr;
        @(negedge sys_clk);
        release_bus();
        timed_out = 1'b1;
        data      = 'x;
        for (n = 0; n < 6; n++) begin
            @(posedge sys_clk);
            #1;
            if (bus_rvalid === 1'b1) begin
                data      = bus_rdata;
                timed_out = 1'b0;
                break;
            end
        end
    endtask : bus_read
endmodule : fsq_host_model

// *** sim/flash_program_erase_sequencer_bench.sv ***
`timescale 1ns/100ps
module flash_program_erase_sequencer_bench
    import fsq_pkg::*;
;
    logic              sys_clk, rst, bus_wr, bus_rd, bus_rvalid;
    logic [ADDR_W-1:0] bus_addr;
    logic [DATA_W-1:0] bus_wdata, bus_rdata;
    logic              gre, lock0, lock1, susp, poll;
    logic              ready, perr, eerr, act, rsf;
    logic [7:0]        flags;
    logic [2:0]        prot [3] = '{3'h0, 3'h6, 3'h5};
    int                n_mismatch = 0;
    int                n_compared = 0;
    int                n;

    // Bits: ready, program error, erase error, active, status mode
    assign flags = {3'h0, ready, perr, eerr, act, rsf};

    fsq_sequencer DUT (
        .sys_clk(sys_clk), .rst(rst), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_rvalid(bus_rvalid), .global_rewrite_enable(gre), .block_zero_lock(lock0),
        .block_one_lock(lock1), .suspend_enable(susp), .status_polling_rewrite_mode(poll),
        .sequencer_ready_flag(ready), .program_error_flag(perr), .erase_error_flag(eerr),
        .program_active_flag(act), .read_status_flag(rsf)
    );

    fsq_host_model u_host (
        .sys_clk(sys_clk), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic timeout();
        n_mismatch++;
        $display("Error at %0t: wait limit reached", $time);
        test_done();
    endtask : timeout

    // Ends on a falling edge so the next input change lands there
    task automatic settle();
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : settle

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       to;
        u_host.bus_read(a, d, to);
        if (to) timeout();
        chk(d, exp);
        @(negedge sys_clk);
    endtask : rd

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        u_host.bus_write(a, d);
        settle();
    endtask : wr

    task automatic prog(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        u_host.program_byte(a, d);
        settle();
    endtask : prog

    task automatic erase(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        u_host.erase_block(a, d);
        settle();
    endtask : erase

    task automatic wait_idle(output int cnt);
        cnt = 0;
        while ((ready !== 1'b1 || act !== 1'b0) && cnt < 300) begin
            settle();
            cnt++;
        end
        if (cnt >= 300) timeout();
    endtask : wait_idle

    initial begin
        rst   = 1'b1;
        gre   = 1'b1;
        lock0 = 1'b0;
        lock1 = 1'b0;
        susp  = 1'b0;
        poll  = 1'b1;
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        settle();
        chk(flags, 8'h10);
        rd(6'h05, ERASED_BYTE);
        prog(6'h05, 8'h5a);
        chk(flags, 8'h01);
        rd(6'h00, 8'h00);
        wait_idle(n);
        chk(flags, 8'h11);
        rd(6'h3f, 8'h80);
        wr(6'h00, CMD_READ_ARRAY);
        chk(flags, 8'h10);
        rd(6'h05, 8'h5a);
        rd(6'h04, 8'hff);
        rd(6'h06, 8'hff);
        susp = 1'b1;
        prog(6'h06, 8'h33);
        chk(flags, 8'h13);
        wait_idle(n);
        chk(flags, 8'h11);
        susp = 1'b0;
        // Ones over cleared bits must fail verify
        prog(6'h05, 8'hff);
        wait_idle(n);
        chk(flags, 8'h19);
        rd(6'h00, 8'h90);
        erase(6'h20, CMD_ERASE_GO);
        chk(flags, 8'h19);
        prog(6'h21, 8'h00);
        chk(flags, 8'h19);
        wr(6'h00, CMD_CLEAR_STATUS);
        chk(flags, 8'h11);
        rd(6'h00, 8'h80);
        for (int i = 0; i < 6; i++) begin
            {gre, lock0, lock1} = prot[i % 3];
            if (i < 3) prog((i == 2) ? 6'h26 : 6'h06, 8'h00);
            else erase((i == 5) ? 6'h26 : 6'h06, CMD_ERASE_GO);
            chk(flags, 8'h11);
        end
        {gre, lock0, lock1} = 3'h4;
        wr(6'h00, CMD_READ_ARRAY);
        rd(6'h06, 8'h33);
        rd(6'h26, 8'hff);
        erase(6'h1f, CMD_ERASE_GO);
        chk(flags, 8'h01);
        rd(6'h00, 8'h00);
        wait_idle(n);
        chk({7'h0, n >= 50}, 8'h01);
        chk(flags, 8'h11);
        rd(6'h00, 8'h80);
        wr(6'h00, CMD_READ_ARRAY);
        for (int i = 0; i < 32; i += 5) rd(6'(i), 8'hff);
        poll = 1'b0;
        prog(6'h22, 8'h0f);
        chk(flags, 8'h00);
        wait_idle(n);
        chk(flags, 8'h10);
        rd(6'h22, 8'h0f);
        erase(6'h3a, CMD_ERASE_GO);
        wait_idle(n);
        rd(6'h22, 8'hff);
        rd(6'h05, 8'hff);
        poll = 1'b1;
        wr(6'h00, CMD_READ_STATUS);
        chk(flags, 8'h11);
        rd(6'h10, 8'h80);
        erase(6'h30, 8'h12);
        chk(flags, 8'h1d);
        wr(6'h00, CMD_CLEAR_STATUS);
        erase(6'h30, CMD_READ_ARRAY);
        chk(flags, 8'h10);
        wr(6'h00, 8'h99);
        chk(flags, 8'h1c);
        wr(6'h00, CMD_CLEAR_STATUS);
        chk(flags, 8'h10);
        test_done();
    end
endmodule : flash_program_erase_sequencer_bench
